// ==== dv/iimc_properties.sv ====
`timescale 1ns/1ps
module iimc_chk #(
  parameter int SAMPLE_DIV = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sel_strap,
  input wire logic converter_drive_en,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic ale,
  input wire logic host_bus_oe_n,
  input wire logic dev_bus_oe_n,
  input wire logic sdo_oe_n,
  input wire logic converter_switch_a_oe_n
);
  // ----------------------------------------
  // switch activity counter
  // ----------------------------------------
  // generous bound: covers the halved rate too
  localparam int SW_LIM = 4 * SAMPLE_DIV + 4;
  int sw_cnt;
  logic sw_prev;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sw_cnt <= 0;
      sw_prev <= 1'b1;
    end else begin
      sw_prev <= converter_switch_a_oe_n;
      sw_cnt <= (sw_prev != converter_switch_a_oe_n) ? 0 : sw_cnt + 1;
    end
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_rd_start;
    !cs_n && $fell(rd_n);
  endsequence
  sequence s_rd_drive;
    !dev_bus_oe_n [*3];
  endsequence

  AST_RD_ANSWER: assert property (s_rd_start |=> s_rd_drive)
    else $error("device did not answer a read strobe");
  AST_RD_RELEASE: assert property (rd_n && $past(rd_n) |-> dev_bus_oe_n)
    else $error("bus driven without read strobe");
  AST_WR_NODRIVE: assert property (!wr_n |-> dev_bus_oe_n)
    else $error("bus driven during write");
  AST_ALE_NODRIVE: assert property (ale && !cs_n |-> dev_bus_oe_n)
    else $error("bus driven during address phase");
  AST_NO_CONTENTION: assert property (!dev_bus_oe_n |-> host_bus_oe_n)
    else $error("both ends drive the bus");
  AST_CS_OFF: assert property (cs_n && $past(cs_n) |-> dev_bus_oe_n)
    else $error("bus driven while deselected");
  AST_SDO_PAR: assert property (!sel_strap || cs_n |-> sdo_oe_n)
    else $error("serial output driven");
  AST_SW_TOGGLE: assert property (converter_drive_en |-> sw_cnt < SW_LIM)
    else $error("converter switch stopped toggling");
endmodule : iimc_chk

// ==== dv/test_isolated_input_mode_sync_error_ctrl.sv ====
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      n_errors++; \
      $display("Error at %0t: got %0h expected %0h", $time, (got), (exp)); \
    end \
  end
module test_isolated_input_mode_sync_error_ctrl
  import iimc_pkg::*;
;
  localparam int SDIV = 16;
  logic mclk;
  logic rst_n;
  logic [3:0] sw_addr [2];
  logic [7:0] sw_wdata [2];
  logic sw_wr [2];
  logic sw_rd [2];
  logic [7:0] sw_rdata [2];
  logic [7:0] ind [2];
  logic mode_s [2];
  logic fault_w [2];
  logic swa [2];
  logic swb [2];
  logic sdo_off [2];
  logic [7:0] sense;
  logic [3:0] flt;
  logic type_strap;
  logic wire_strap;
  logic sync_lvl;
  int n_errors;
  int comparisons;

  always #12.5 mclk = ~mclk;

  // ----------------------------------------
  // pair 0 parallel with drive, pair 1 serial
  // ----------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_pair
    iimc_if lnk ();
    iimc_host #(.SERIAL_MODE(g == 1), .DC_EN(g == 0), .STEP_CYC(4)) iimc_host_i (
      .mclk(mclk),
      .rst_n(rst_n),
      .lnk(lnk),
      .sw_addr(sw_addr[g]),
      .sw_wdata(sw_wdata[g]),
      .sw_wr(sw_wr[g]),
      .sw_rd(sw_rd[g]),
      .sw_rdata(sw_rdata[g])
    );
    iimc_dev #(.SAMPLE_DIV(SDIV)) iimc_dev_i (
      .mclk(mclk),
      .rst_n(rst_n),
      .lnk(lnk),
      .channel_sense_in(sense),
      .channel_indicator_out(ind[g]),
      .sensor_type_strap(type_strap),
      .open_wire_level_strap(wire_strap),
      .supply_uv(flt[0]),
      .supply_mv(flt[1]),
      .xfer_fail(flt[2]),
      .conv_overcurrent(flt[3]),
      .mode_serial(mode_s[g])
    );
    assign fault_w[g] = lnk.fault_n;
    assign swa[g] = lnk.converter_switch_a_oe_n;
    assign swb[g] = lnk.converter_switch_b_oe_n;
    assign sdo_off[g] = lnk.sdo_oe_n;
  end

  iimc_chk #(.SAMPLE_DIV(SDIV)) iimc_chk_i (
    .mclk(mclk),
    .rst_n(rst_n),
    .sel_strap(g_pair[0].lnk.sel_strap),
    .converter_drive_en(g_pair[0].lnk.converter_drive_en),
    .cs_n(g_pair[0].lnk.cs_n),
    .rd_n(g_pair[0].lnk.rd_n),
    .wr_n(g_pair[0].lnk.wr_n),
    .ale(g_pair[0].lnk.ale),
    .host_bus_oe_n(g_pair[0].lnk.host_bus_oe_n),
    .dev_bus_oe_n(g_pair[0].lnk.dev_bus_oe_n),
    .sdo_oe_n(g_pair[0].lnk.sdo_oe_n),
    .converter_switch_a_oe_n(g_pair[0].lnk.converter_switch_a_oe_n)
  );

  // ----------------------------------------
  // software port tasks
  // ----------------------------------------
  task sw_write(input int h, input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    sw_addr[h] <= a;
    sw_wdata[h] <= d;
    sw_wr[h] <= 1'b1;
    @(posedge mclk);
    sw_wr[h] <= 1'b0;
  endtask : sw_write

  task sw_read(input int h, input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    sw_addr[h] <= a;
    sw_rd[h] <= 1'b1;
    @(posedge mclk);
    sw_rd[h] <= 1'b0;
    #1;
    d = sw_rdata[h];
  endtask : sw_read

  // one device access through the controller, polling busy with a bound
  task automatic dev_access(input int h, input logic wr, input logic [6:0] a,
                            input logic [7:0] wd, output logic [7:0] rd);
    logic [7:0] c;
    logic [7:0] s;
    int n;
    c = 8'h00;
    c[CTRL_SYNC_BIT] = sync_lvl;
    c[CTRL_WRITE_BIT] = wr;
    c[CTRL_START_BIT] = 1'b1;
    sw_write(h, HREG_ADDR, {1'b0, a});
    sw_write(h, HREG_WDATA, wd);
    sw_write(h, HREG_CTRL, c);
    s = 8'h01;
    n = 0;
    while (s[STAT_BUSY_BIT] !== 1'b0 && n < 300) begin
      sw_read(h, HREG_STAT, s);
      n++;
    end
    `CHK(s[STAT_BUSY_BIT], 1'b0);
    sw_read(h, HREG_RDATA, rd);
  endtask : dev_access

  task automatic set_sync(input logic v);
    sync_lvl = v;
    for (int h = 0; h < 2; h++) sw_write(h, HREG_CTRL, 8'(v) << CTRL_SYNC_BIT);
  endtask : set_sync

  // cycles between two changes of switch a on the parallel pair
  task automatic measure(output int p);
    logic v;
    int n;
    n = 0;
    v = swa[0];
    while (swa[0] === v && n < 500) begin
      @(posedge mclk);
      #1;
      n++;
    end
    v = swa[0];
    p = 0;
    while (swa[0] === v && p < 500) begin
      @(posedge mclk);
      #1;
      p++;
    end
  endtask : measure

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_modes();
    `CHK(mode_s[0], 1'b0);
    `CHK(mode_s[1], 1'b1);
    `CHK(fault_w[0], 1'b1);
    `CHK(swa[1] & swb[1], 1'b1);
    `CHK(sdo_off[1], 1'b1);
    $display("modes test done");
  endtask : t_modes

  task automatic t_freeze();
    logic [7:0] r;
    sense <= 8'hA5;
    repeat (2 * SDIV + 4) @(posedge mclk);
    for (int h = 0; h < 2; h++) begin
      dev_access(h, 1'b0, ADDR_DATA, 8'h00, r);
      `CHK(r, 8'hA5);
    end
    @(posedge mclk);
    sense <= 8'h3C;
    set_sync(1'b0);
    repeat (8) @(posedge mclk);
    sense <= 8'hC3;
    repeat (3 * SDIV) @(posedge mclk);
    for (int h = 0; h < 2; h++) begin
      dev_access(h, 1'b0, ADDR_DATA, 8'h00, r);
      `CHK(r, 8'h3C);
      `CHK(ind[h], 8'hC3);
    end
    set_sync(1'b1);
    repeat (2 * SDIV + 4) @(posedge mclk);
    dev_access(1, 1'b0, ADDR_DATA, 8'h00, r);
    `CHK(r, 8'hC3);
    $display("freeze test done");
  endtask : t_freeze

  task automatic t_fault();
    logic [7:0] r;
    for (int i = 0; i < 4; i++) begin
      flt <= 4'h1 << i;
      repeat (2 * SDIV + 4) @(posedge mclk);
      `CHK({fault_w[0], fault_w[1]}, 2'b00);
      dev_access(i % 2, 1'b0, ADDR_DIAG, 8'h00, r);
      `CHK(r[3:0], 4'h1 << i);
      sw_read(0, HREG_STAT, r);
      `CHK(r[STAT_FAULT_BIT], 1'b1);
      flt <= 4'h0;
      repeat (4) @(posedge mclk);
      `CHK({fault_w[0], fault_w[1]}, 2'b11);
    end
    $display("fault test done");
  endtask : t_fault

  task automatic t_config();
    logic [7:0] r;
    int p1;
    int p2;
    measure(p1);
    dev_access(0, 1'b1, ADDR_CFG, 8'h01, r);
    dev_access(0, 1'b0, ADDR_CFG, 8'h00, r);
    // bit 6 type strap high, bit 7 wire strap low
    `CHK(r, 8'h41);
    measure(p2);
    `CHK(p2, 2 * p1);
    `CHK(swb[0], !swa[0]);
    `CHK(swa[1] & swb[1], 1'b1);
    dev_access(1, 1'b1, 7'h03, 8'h5A, r);
    dev_access(1, 1'b0, 7'h03, 8'h00, r);
    `CHK(r, RD_NONE);
    sw_read(0, 4'hF, r);
    `CHK(r, RD_NONE);
    `CHK(sdo_off[1], 1'b1);
    $display("config test done");
  endtask : t_config

  initial begin
    repeat (60000) @(posedge mclk);
    n_errors++;
    complete_run();
  end

  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    sw_addr = '{4'h0, 4'h0};
    sw_wdata = '{8'h00, 8'h00};
    sw_wr = '{1'b0, 1'b0};
    sw_rd = '{1'b0, 1'b0};
    sense = 8'h00;
    flt = 4'h0;
    type_strap = 1'b1;
    wire_strap = 1'b0;
    sync_lvl = 1'b1;
    n_errors = 0;
    comparisons = 0;
    repeat (10) @(posedge mclk);
    `CHK({mode_s[0], mode_s[1]}, 2'b11);
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_modes();
    t_freeze();
    t_fault();
    t_config();
    complete_run();
  end
endmodule : test_isolated_input_mode_sync_error_ctrl

// ==== hw/iimc_dev.sv ====
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module iimc_dev
  import iimc_pkg::*;
#(
  parameter int SAMPLE_DIV = SAMPLE_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  iimc_if.dev lnk,
  input wire logic [CH_N-1:0] channel_sense_in,
  output logic [CH_N-1:0] channel_indicator_out,
  input wire logic sensor_type_strap,
  input wire logic open_wire_level_strap,
  input wire logic supply_uv,
  input wire logic supply_mv,
  input wire logic xfer_fail,
  input wire logic conv_overcurrent,
  output logic mode_serial
);
  if (SAMPLE_DIV < 2 || SAMPLE_DIV > 65536) $error("SAMPLE_DIV must lie in 2..65536");

  logic started, type_strap_q, wire_strap_q, tick, sync_meta, sync_s, sync_d, sync_fall;
  logic half_q, phase, p_wsel, rd_d, wr_d, rd_act, par_sel, ser_sel, sclk_d;
  logic s_rise, s_fall, p_wr, s_wr;
  logic [15:0] div_cnt;
  logic [CH_N-1:0] data_q;
  logic [DIAG_W-1:0] diag_q, faults;
  logic [7:0] global_config_reg, p_data, s_in, s_cmd, s_out;
  logic [ADDR_W-1:0] p_addr;
  logic [3:0] s_cnt;

  function automatic logic [7:0] rd_mux(input logic [ADDR_W-1:0] a);
    logic [7:0] v;
    v = RD_NONE;
    unique case (a)
      ADDR_DATA: v = data_q;
      ADDR_DIAG: v = 8'(diag_q);
      ADDR_CFG: begin
        v = global_config_reg;
        v[CFG_TYPE_BIT] = type_strap_q;
        v[CFG_WIRE_BIT] = wire_strap_q;
      end
      default: v = RD_NONE;
    endcase
    return v;
  endfunction : rd_mux

  // ----------------------------------------
  // start-up and mode
  // ----------------------------------------
  // straps are caught once, at the first edge after release
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      started <= 1'b0;
      mode_serial <= 1'b1;
      type_strap_q <= 1'b0;
      wire_strap_q <= 1'b0;
    end else if (!started) begin
      started <= 1'b1;
      mode_serial <= lnk.sel_strap;
      type_strap_q <= sensor_type_strap;
      wire_strap_q <= open_wire_level_strap;
    end
  end

  // ----------------------------------------
  // sampling clock
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 16'h0000;
    end else if (div_cnt == 16'(SAMPLE_DIV - 1)) begin
      div_cnt <= 16'h0000;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end
  assign tick = div_cnt == 16'(SAMPLE_DIV - 1);

  // ----------------------------------------
  // freeze input and data registers
  // ----------------------------------------
  // two-stage synchroniser
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync_meta <= 1'b1;
      sync_s <= 1'b1;
      sync_d <= 1'b1;
    end else begin
      sync_meta <= lnk.sync;
      sync_s <= sync_meta;
      sync_d <= sync_s;
    end
  end
  assign sync_fall = sync_d && !sync_s;
  assign faults = {conv_overcurrent, xfer_fail, supply_mv, supply_uv};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      data_q <= 8'h00;
      diag_q <= 4'h0;
    end else if (sync_fall || (sync_s && tick)) begin
      data_q <= channel_sense_in;
      diag_q <= faults;
    end
  end

  // ----------------------------------------
  // indicators and fault output
  // ----------------------------------------
  // indicator per channel
  for (genvar i = 0; i < CH_N; i++) begin : g_ind
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) channel_indicator_out[i] <= 1'b0;
      else channel_indicator_out[i] <= channel_sense_in[i];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lnk.fault_oe_n <= 1'b1;
    end else begin
      lnk.fault_oe_n <= ~|faults;
    end
  end

  // ----------------------------------------
  // converter drive
  // ----------------------------------------
  // toggle, optional halving
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      half_q <= 1'b0;
      phase <= 1'b0;
    end else if (tick) begin
      half_q <= !half_q;
      if (!global_config_reg[CFG_HALVE_BIT] || half_q) phase <= !phase;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lnk.converter_switch_a_oe_n <= 1'b1;
      lnk.converter_switch_b_oe_n <= 1'b1;
    end else begin
      lnk.converter_switch_a_oe_n <= !lnk.converter_drive_en || phase;
      lnk.converter_switch_b_oe_n <= !lnk.converter_drive_en || !phase;
    end
  end

  // ----------------------------------------
  // parallel port
  // ----------------------------------------
  // gated by chip select
  assign par_sel = !mode_serial && !lnk.cs_n;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      p_addr <= 7'h00;
      p_wsel <= 1'b0;
    end else if (par_sel && lnk.ale) begin
      p_addr <= lnk.parallel_bus[ADDR_W-1:0];
      p_wsel <= lnk.parallel_bus[RW_BIT];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_d <= 1'b1;
      wr_d <= 1'b1;
      rd_act <= 1'b0;
      p_data <= 8'h00;
    end else begin
      rd_d <= lnk.rd_n;
      wr_d <= lnk.wr_n;
      if (par_sel && !lnk.ale && !p_wsel && rd_d && !lnk.rd_n) begin
        rd_act <= 1'b1;
        p_data <= rd_mux(p_addr);
      end else if (!par_sel || lnk.rd_n) begin
        rd_act <= 1'b0;
      end
    end
  end
  assign lnk.dev_bus_out = p_data;
  assign lnk.dev_bus_oe_n = !rd_act;
  assign p_wr = par_sel && !lnk.ale && p_wsel && wr_d && !lnk.wr_n;

  // ----------------------------------------
  // serial port
  // ----------------------------------------
  assign ser_sel = mode_serial && !lnk.cs_n;
  assign s_rise = ser_sel && !sclk_d && lnk.sclk;
  assign s_fall = ser_sel && sclk_d && !lnk.sclk;
  assign s_wr = s_rise && s_cnt == 4'(SER_BITS - 1) && s_cmd[RW_BIT];
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d <= 1'b0;
      s_cnt <= 4'h0;
      s_in <= 8'h00;
      s_cmd <= 8'h00;
      s_out <= 8'h00;
      lnk.sdo <= 1'b0;
    end else begin
      sclk_d <= lnk.sclk;
      if (!ser_sel) begin
        s_cnt <= 4'h0;
      end else if (s_rise) begin
        s_in <= {s_in[6:0], lnk.sdi};
        s_cnt <= s_cnt + 4'h1;
        if (s_cnt == 4'(BUS_W - 1)) begin
          s_cmd <= {s_in[6:0], lnk.sdi};
          s_out <= rd_mux({s_in[5:0], lnk.sdi});
        end
      end else if (s_fall && s_cnt[3]) begin
        lnk.sdo <= s_out[7];
        s_out <= {s_out[6:0], 1'b0};
      end
    end
  end
  assign lnk.sdo_oe_n = !ser_sel;

  // ----------------------------------------
  // configuration register
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      global_config_reg <= CFG_RST;
    end else if (p_wr && p_addr == ADDR_CFG) begin
      global_config_reg <= lnk.parallel_bus;
    end else if (s_wr && s_cmd[ADDR_W-1:0] == ADDR_CFG) begin
      global_config_reg <= {s_in[6:0], lnk.sdi};
    end
  end
endmodule : iimc_dev

// ==== hw/iimc_host.sv ====
`timescale 1ns/1ps
module iimc_host
  import iimc_pkg::*;
#(
  parameter bit SERIAL_MODE = 1'b1,
  parameter bit DC_EN = 1'b0,
  parameter int STEP_CYC = HSTEP_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  iimc_if.host lnk,
  input wire logic [3:0] sw_addr,
  input wire logic [7:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [7:0] sw_rdata
);
  // step counter is 16 bits wide and a half-bit needs three cycles
  if (STEP_CYC < 3 || STEP_CYC > 65536) $error("STEP_CYC must lie in 3..65536");

  iimc_hstate_t state;
  logic [15:0] step_cnt;
  logic tick;
  logic [ADDR_W-1:0] t_addr;
  logic [7:0] t_wdata;
  logic [7:0] rdata;
  logic t_write;
  logic sync_lvl;
  logic [3:0] bitn;
  logic [SER_BITS-1:0] frame;
  logic [SER_BITS-1:0] rx;
  logic start;

  // ----------------------------------------
  // straps and static levels
  // ----------------------------------------
  // strap fixed
  assign lnk.sel_strap = SERIAL_MODE;
  assign lnk.converter_drive_en = DC_EN;
  assign lnk.sync = sync_lvl;
  assign start = sw_wr && sw_addr == HREG_CTRL && sw_wdata[CTRL_START_BIT]
                 && state == HS_IDLE;

  // ----------------------------------------
  // step divider
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      step_cnt <= 16'h0000;
    end else if (state == HS_IDLE || step_cnt == 16'(STEP_CYC - 1)) begin
      step_cnt <= 16'h0000;
    end else begin
      step_cnt <= step_cnt + 16'h0001;
    end
  end
  assign tick = step_cnt == 16'(STEP_CYC - 1);

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      t_addr <= 7'h00;
      t_wdata <= 8'h00;
      sync_lvl <= 1'b1;
    end else if (sw_wr) begin
      if (sw_addr == HREG_ADDR) t_addr <= sw_wdata[ADDR_W-1:0];
      if (sw_addr == HREG_WDATA) t_wdata <= sw_wdata;
      if (sw_addr == HREG_CTRL) sync_lvl <= sw_wdata[CTRL_SYNC_BIT];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sw_rdata <= 8'h00;
    end else if (sw_rd) begin
      unique case (sw_addr)
        HREG_ADDR: sw_rdata <= {1'b0, t_addr};
        HREG_WDATA: sw_rdata <= t_wdata;
        HREG_CTRL: sw_rdata <= 8'({sync_lvl, t_write, 1'b0});
        HREG_STAT: sw_rdata <= 8'({!lnk.fault_n, state != HS_IDLE});
        HREG_RDATA: sw_rdata <= rdata;
        default: sw_rdata <= 8'h00;
      endcase
    end else begin
      sw_rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // transfer sequencer
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= HS_IDLE;
      t_write <= 1'b0;
      lnk.cs_n <= 1'b1;
      lnk.ale <= 1'b0;
      lnk.rd_n <= 1'b1;
      lnk.wr_n <= 1'b1;
      lnk.host_bus_out <= 8'h00;
      lnk.host_bus_oe_n <= 1'b1;
      lnk.sclk <= 1'b0;
      lnk.sdi <= 1'b0;
      bitn <= 4'h0;
      frame <= 16'h0000;
      rx <= 16'h0000;
      rdata <= 8'h00;
    end else begin
      unique case (state)
        HS_IDLE: begin
          if (start) begin
            t_write <= sw_wdata[CTRL_WRITE_BIT];
            lnk.cs_n <= 1'b0;
            if (SERIAL_MODE) begin
              frame <= {sw_wdata[CTRL_WRITE_BIT], t_addr, t_wdata};
              lnk.sdi <= sw_wdata[CTRL_WRITE_BIT];
              bitn <= 4'h0;
              state <= HS_SHIFT;
            end else begin
              lnk.ale <= 1'b1;
              lnk.host_bus_oe_n <= 1'b0;
              lnk.host_bus_out <= {sw_wdata[CTRL_WRITE_BIT], t_addr};
              state <= HS_ALE;
            end
          end
        end
        HS_ALE: begin
          if (tick) begin
            lnk.ale <= 1'b0;
            if (t_write) begin
              lnk.host_bus_out <= t_wdata;
              lnk.wr_n <= 1'b0;
            end else begin
              lnk.host_bus_oe_n <= 1'b1;
              lnk.rd_n <= 1'b0;
            end
            state <= HS_STRB;
          end
        end
        HS_STRB: begin
          if (tick) begin
            if (!t_write) rdata <= lnk.parallel_bus;
            lnk.rd_n <= 1'b1;
            lnk.wr_n <= 1'b1;
            lnk.host_bus_oe_n <= 1'b1;
            state <= HS_DONE;
          end
        end
        HS_SHIFT: begin
          if (tick) begin
            if (!lnk.sclk) begin
              lnk.sclk <= 1'b1;
              rx <= {rx[SER_BITS-2:0], lnk.sdo};
            end else begin
              lnk.sclk <= 1'b0;
              bitn <= bitn + 4'h1;
              frame <= {frame[SER_BITS-2:0], 1'b0};
              lnk.sdi <= frame[SER_BITS-2];
              if (bitn == 4'(SER_BITS - 1)) begin
                if (!t_write) rdata <= rx[7:0];
                state <= HS_DONE;
              end
            end
          end
        end
        HS_DONE: begin
          if (tick) begin
            lnk.cs_n <= 1'b1;
            lnk.sdi <= 1'b0;
            state <= HS_IDLE;
          end
        end
        default: state <= HS_IDLE;
      endcase
    end
  end
endmodule : iimc_host

// ==== inc/iimc_if.sv ====
`timescale 1ns/1ps
interface iimc_if;
  import iimc_pkg::*;
  logic sel_strap;
  logic converter_drive_en;
  logic sync;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic ale;
  logic [BUS_W-1:0] host_bus_out;
  logic host_bus_oe_n;
  logic [BUS_W-1:0] dev_bus_out;
  logic dev_bus_oe_n;
  logic [BUS_W-1:0] parallel_bus;
  logic sclk;
  logic sdi;
  logic sdo;
  logic sdo_oe_n;
  logic fault_oe_n;
  logic fault_n;
  logic converter_switch_a_oe_n;
  logic converter_switch_b_oe_n;

  // wire levels, pull-ups where nobody drives
  assign parallel_bus = !dev_bus_oe_n ? dev_bus_out :
                        !host_bus_oe_n ? host_bus_out : BUS_IDLE;
  assign fault_n = fault_oe_n;

  modport dev (
    input sel_strap, converter_drive_en, sync, cs_n, rd_n, wr_n, ale,
    input parallel_bus, sclk, sdi,
    output dev_bus_out, dev_bus_oe_n, sdo, sdo_oe_n, fault_oe_n,
    output converter_switch_a_oe_n, converter_switch_b_oe_n
  );
  modport host (
    output sel_strap, converter_drive_en, sync, cs_n, rd_n, wr_n, ale,
    output host_bus_out, host_bus_oe_n, sclk, sdi,
    input parallel_bus, sdo, fault_n
  );
endinterface : iimc_if

// ==== inc/iimc_pkg.sv ====
package iimc_pkg;
  // ----------------------------------------
  // link widths
  // ----------------------------------------
  localparam int CH_N = 8;
  localparam int BUS_W = 8;
  localparam int ADDR_W = 7;
  localparam int RW_BIT = 7;
  localparam int SER_BITS = 16;

  // ----------------------------------------
  // device register map
  // ----------------------------------------
  localparam logic [6:0] ADDR_DATA = 7'h00;
  localparam logic [6:0] ADDR_DIAG = 7'h01;
  localparam logic [6:0] ADDR_CFG = 7'h02;
  localparam int CFG_HALVE_BIT = 0;
  localparam int CFG_TYPE_BIT = 6;
  localparam int CFG_WIRE_BIT = 7;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] BUS_IDLE = 8'hFF;
  localparam logic [7:0] RD_NONE = 8'h00;
  localparam int DIAG_W = 4;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_NS = 25;
  localparam int SAMPLE_NS = 2000;
  localparam int SAMPLE_CYC = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HSTEP_NS = 100;
  localparam int HSTEP_CYC = (HSTEP_NS + CLK_NS - 1) / CLK_NS;

  // ----------------------------------------
  // controller software registers
  // ----------------------------------------
  localparam logic [3:0] HREG_ADDR = 4'h0;
  localparam logic [3:0] HREG_WDATA = 4'h1;
  localparam logic [3:0] HREG_CTRL = 4'h2;
  localparam logic [3:0] HREG_STAT = 4'h3;
  localparam logic [3:0] HREG_RDATA = 4'h4;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_WRITE_BIT = 1;
  localparam int CTRL_SYNC_BIT = 2;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_FAULT_BIT = 1;

  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_ALE = 3'b001,
    HS_STRB = 3'b010,
    HS_SHIFT = 3'b011,
    HS_DONE = 3'b100
  } iimc_hstate_t;
endpackage : iimc_pkg
